// File: hdl/uca_chan.sv
// Serial channel A pins, straps, transmit buffer and modem lines
`timescale 1ns/1ps
`default_nettype none
`include "uca_regs.svh"

module uca_chan (
    // Clock, reset, clock enable
    input wire logic mclk,
    input wire logic rstn,
    input wire logic ce,
    // Transmit stream into the two-entry buffer
    input wire logic tx_valid,
    output logic tx_ready,
    input wire logic [7:0] tx_data,
    // Received characters
    output logic rx_valid,
    output logic [7:0] rx_data,
    output logic rx_frame_err,
    // Line setup
    input wire logic [15:0] baud_div,
    input wire logic ir_mode,
    // Configuration write port
    input wire logic cfg_wr,
    input wire logic [7:0] cfg_addr,
    input wire logic [7:0] cfg_wdata,
    // Configuration state
    output logic cfg_enable,
    output logic [7:0] cfg_base_hi,
    output logic [7:0] cfg_base_lo,
    output logic [7:0] cfg_irq_sel,
    output logic cfg_clk_sel,
    output logic [7:0] cfg_index_port,
    output logic [7:0] cfg_data_port,
    output logic straps_done,
    // Serial pins
    input wire logic chan_serial_in,
    input wire logic chan_serial_out_i,
    output logic chan_serial_out_o,
    output logic chan_serial_out_oe,
    input wire logic infrared_in,
    output logic infrared_out,
    // Modem status pins and their readings
    input wire logic chan_clear_to_send_n,
    input wire logic chan_set_ready_n,
    input wire logic chan_carrier_detect_n,
    input wire logic chan_ring_indicator_n,
    output logic [3:0] modem_status,
    output logic [3:0] gpio_in,
    // Modem control requests
    input wire logic rts_assert,
    input wire logic dtr_assert,
    input wire logic [1:0] gpo_mode,
    input wire logic [1:0] gpo_level,
    // Modem control strap pins
    input wire logic chan_request_to_send_n_i,
    output logic chan_request_to_send_n_o,
    output logic chan_request_to_send_n_oe,
    input wire logic chan_terminal_ready_n_i,
    output logic chan_terminal_ready_n_o,
    output logic chan_terminal_ready_n_oe,
    // Watchdog
    input wire logic watchdog_fire,
    output logic watchdog_out_n_o,
    output logic watchdog_out_n_oe
);
    import uca_pkg::*;

    uca_state_t st;
    uca_state_t next_st;
    logic [8:0] pins;
    logic push;
    logic pop;
    logic rx_line;
    logic [1:0] cnt_after;

    // ==========================================================
    // Pin gathering
    assign pins = {chan_request_to_send_n_i, chan_terminal_ready_n_i, chan_serial_out_i,
                   chan_ring_indicator_n, chan_carrier_detect_n, chan_set_ready_n,
                   chan_clear_to_send_n, infrared_in, chan_serial_in};
    // Receive source: infrared is inverted so quiet low reads as idle high
    assign rx_line = ir_mode ? ~st.filt[`UCA_PIN_IR] : st.filt[`UCA_PIN_RX];
    // Buffer handshake
    assign tx_ready = (st.buf_cnt != `UCA_BUF_DEPTH) && (st.phase == UCA_PH_RUN);
    assign push = tx_valid && tx_ready;
    assign pop = (st.buf_cnt != 2'h0) && !st.tx_busy && st.cfg_enable;
    assign cnt_after = pop ? st.buf_cnt - 2'h1 : st.buf_cnt;

    // ==========================================================
    // Next state
    always_comb begin
        next_st = st;
        next_st.rx_valid = 1'b0;
        // Three-stage synchronisers, accepted once stages two and three agree
        next_st.s1 = pins;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        for (int i = 0; i < 9; i++) begin
            if (st.s2[i] == st.s3[i]) begin
                next_st.filt[i] = st.s3[i];
            end
        end
        // Strap settle then capture on release of reset
        case (st.phase)
            UCA_PH_RESET: begin
                next_st.phase = UCA_PH_SETTLE;
                next_st.settle_cnt = 2'h0;
            end
            UCA_PH_SETTLE: begin
                next_st.settle_cnt = st.settle_cnt + 2'h1;
                if (st.settle_cnt == `UCA_SETTLE_LAST) begin
                    next_st.phase = UCA_PH_RUN;
                    next_st.cfg_enable = 1'b0;
                    next_st.base_hi = 8'h00;
                    next_st.base_lo = 8'h00;
                    next_st.irq_sel = 8'h00;
                    if (st.filt[`UCA_PIN_TX]) begin
                        next_st.cfg_enable = (`UCA_STRAP_ENABLE != 8'h00);
                        next_st.base_hi = `UCA_STRAP_BASE_HI;
                        next_st.base_lo = `UCA_STRAP_LO_TX;
                        next_st.irq_sel = `UCA_STRAP_IRQ;
                    end else if (st.filt[`UCA_PIN_DTR]) begin
                        next_st.cfg_enable = (`UCA_STRAP_ENABLE != 8'h00);
                        next_st.base_hi = `UCA_STRAP_BASE_HI;
                        next_st.base_lo = `UCA_STRAP_LO_DTR;
                        next_st.irq_sel = `UCA_STRAP_IRQ;
                    end
                    next_st.cfg_port = st.filt[`UCA_PIN_RTS] ? `UCA_PORT_HIGH_STRAP
                                                           : `UCA_PORT_LOW_STRAP;
                end
            end
            UCA_PH_RUN: begin
                // Software overwrites strap defaults; straps never reload here
                if (cfg_wr) begin
                    if (cfg_addr == `UCA_CFG_ENABLE) begin
                        next_st.cfg_enable = cfg_wdata[0];
                    end else if (cfg_addr == `UCA_CFG_BASE_HI) begin
                        next_st.base_hi = cfg_wdata;
                    end else if (cfg_addr == `UCA_CFG_BASE_LO) begin
                        next_st.base_lo = cfg_wdata;
                    end else if (cfg_addr == `UCA_CFG_IRQ_SEL) begin
                        next_st.irq_sel = cfg_wdata;
                    end else if (cfg_addr == `UCA_CFG_CLK_SEL) begin
                        next_st.clk_sel = cfg_wdata[0];
                    end
                end
            end
            default: begin
                next_st.phase = UCA_PH_RESET;
            end
        endcase
        // Oversample tick, sixteen per bit
        next_st.tick = 1'b0;
        if (st.div_cnt >= baud_div) begin
            next_st.div_cnt = 16'h0000;
            next_st.tick = 1'b1;
        end else begin
            next_st.div_cnt = st.div_cnt + 16'h0001;
        end
        // Two-entry transmit buffer
        if (pop) begin
            next_st.buf0 = st.buf1;
            next_st.tx_busy = 1'b1;
            next_st.tx_shift = {1'b1, st.buf0, 1'b0};
            next_st.tx_bit = 4'h0;
            next_st.tx_os = 4'h0;
        end
        if (push) begin
            if (cnt_after == 2'h0) begin
                next_st.buf0 = tx_data;
            end else begin
                next_st.buf1 = tx_data;
            end
        end
        next_st.buf_cnt = cnt_after + {1'b0, push};
        // Transmitter, LSB first, one stop bit
        if (st.tx_busy && st.tick) begin
            next_st.tx_os = st.tx_os + 4'h1;
            if (st.tx_os == `UCA_OVS_LAST) begin
                next_st.tx_shift = {1'b1, st.tx_shift[9:1]};
                next_st.tx_bit = st.tx_bit + 4'h1;
                if (st.tx_bit == `UCA_BIT_STOP) begin
                    next_st.tx_busy = 1'b0;
                end
            end
        end
        // Wire line high when idle; infrared pulses low bits in first three sixteenths
        next_st.tx_line = !(st.tx_busy && !ir_mode && !st.tx_shift[0]);
        next_st.ir_line = st.tx_busy && ir_mode && !st.tx_shift[0]
                          && (st.tx_os < `UCA_IR_PULSE_END);
        // Receiver, mid-bit sampling, false starts dropped
        if (!st.rx_busy) begin
            if (st.phase == UCA_PH_RUN && !rx_line) begin
                next_st.rx_busy = 1'b1;
                next_st.rx_os = 4'h0;
                next_st.rx_bit = 4'h0;
            end
        end else if (st.tick) begin
            next_st.rx_os = st.rx_os + 4'h1;
            if (st.rx_os == `UCA_OVS_MID) begin
                next_st.rx_bit = st.rx_bit + 4'h1;
                if (st.rx_bit == 4'h0) begin
                    next_st.rx_busy = !rx_line;
                end else if (st.rx_bit == `UCA_BIT_STOP) begin
                    next_st.rx_busy = 1'b0;
                    next_st.rx_data = st.rx_shift;
                    next_st.rx_valid = 1'b1;
                    next_st.rx_frame_err = !rx_line;
                end else begin
                    next_st.rx_shift = {rx_line, st.rx_shift[7:1]};
                end
            end
        end
        // Modem status as asserted flags and raw input levels
        next_st.modem_status = ~st.filt[`UCA_PIN_MODEM_HI:`UCA_PIN_MODEM_LO];
        next_st.gpio_in = st.filt[`UCA_PIN_MODEM_HI:`UCA_PIN_MODEM_LO];
        // Modem controls active low or plain outputs
        next_st.rts_n = gpo_mode[0] ? gpo_level[0] : !rts_assert;
        next_st.dtr_n = gpo_mode[1] ? gpo_level[1] : !dtr_assert;
        next_st.wdt_drive = watchdog_fire;
    end

    // ==========================================================
    // State register with clock enable
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            st <= '0;
            st.phase <= UCA_PH_RESET;
            st.s1 <= `UCA_PIN_IDLE;
            st.s2 <= `UCA_PIN_IDLE;
            st.s3 <= `UCA_PIN_IDLE;
            st.filt <= `UCA_PIN_IDLE;
            st.tx_line <= 1'b1;
            st.ir_line <= 1'b0;
            st.clk_sel <= `UCA_CLK_SEL_24;
            st.cfg_port <= `UCA_PORT_HIGH_STRAP;
            st.rts_n <= 1'b1;
            st.dtr_n <= 1'b1;
        end else if (ce) begin
            st <= next_st;
        end
    end

    // ==========================================================
    // Outputs; strap pins float on their pull-ups until the straps are taken
    assign straps_done = (st.phase == UCA_PH_RUN);
    assign chan_serial_out_o = st.tx_line;
    assign chan_serial_out_oe = straps_done;
    assign chan_request_to_send_n_o = st.rts_n;
    assign chan_request_to_send_n_oe = straps_done;
    assign chan_terminal_ready_n_o = st.dtr_n;
    assign chan_terminal_ready_n_oe = straps_done;
    assign infrared_out = st.ir_line;
    assign watchdog_out_n_o = 1'b0;
    assign watchdog_out_n_oe = st.wdt_drive;
    assign rx_valid = st.rx_valid;
    assign rx_data = st.rx_data;
    assign rx_frame_err = st.rx_frame_err;
    assign modem_status = st.modem_status;
    assign gpio_in = st.gpio_in;
    assign cfg_enable = st.cfg_enable;
    assign cfg_base_hi = st.base_hi;
    assign cfg_base_lo = st.base_lo;
    assign cfg_irq_sel = st.irq_sel;
    assign cfg_clk_sel = st.clk_sel;
    assign cfg_index_port = st.cfg_port;
    assign cfg_data_port = st.cfg_port + 8'h01;

endmodule : uca_chan
`default_nettype wire

// File: hdl/uca_regs.svh
// Constants of the serial channel A pin and strap block
//
// Function
// - Serial out high in reset and idle
// - Infrared out low in reset and idle
// - Infrared in idles low, low is quiet
// - Serial in idles high between characters
// - Modem inputs active low, or plain inputs
// - RTS and DTR active low, or outputs
// - Strap pins pulled up, sampled every reset
// - TX and DTR straps pick default config
// - Strap defaults loaded, software may overwrite
// - One reference clock, 24 or 48 MHz
// - Watchdog output open drain, active low
// - RTS strap picks 0x2E or 0x4E port
// - Clock select 0x1 is 48, 0x0 is 24
`ifndef UCA_REGS_SVH
`define UCA_REGS_SVH

// ==========================================================
// Configuration register offsets
`define UCA_CFG_ENABLE 8'h30
`define UCA_CFG_BASE_HI 8'h60
`define UCA_CFG_BASE_LO 8'h61
`define UCA_CFG_IRQ_SEL 8'h70
`define UCA_CFG_CLK_SEL 8'h25

// ==========================================================
// Strap derived values
`define UCA_STRAP_ENABLE 8'h01
`define UCA_STRAP_BASE_HI 8'h03
`define UCA_STRAP_LO_TX 8'hF8
`define UCA_STRAP_LO_DTR 8'hE0
`define UCA_STRAP_IRQ 8'h03
`define UCA_PORT_HIGH_STRAP 8'h2E
`define UCA_PORT_LOW_STRAP 8'h4E
`define UCA_CLK_SEL_48 1'h1
`define UCA_CLK_SEL_24 1'h0

// ==========================================================
// Pin vector bits and idle levels
`define UCA_PIN_RX 0
`define UCA_PIN_IR 1
`define UCA_PIN_MODEM_LO 2
`define UCA_PIN_MODEM_HI 5
`define UCA_PIN_TX 6
`define UCA_PIN_DTR 7
`define UCA_PIN_RTS 8
`define UCA_PIN_IDLE 9'h1FD

// ==========================================================
// Timing counts
`define UCA_SETTLE_LAST 2'h3
`define UCA_OVS_MID 4'h7
`define UCA_OVS_LAST 4'hF
`define UCA_IR_PULSE_END 4'h3
`define UCA_BIT_STOP 4'h9
`define UCA_BUF_DEPTH 2'h2

`endif

// File: hdl/uca_pkg.sv
// Types of the serial channel A pin and strap block
package uca_pkg;

    // Phases after reset release, Gray coded
    typedef enum logic [1:0] {
        UCA_PH_RESET = 2'h0,
        UCA_PH_SETTLE = 2'h1,
        UCA_PH_RUN = 2'h3
    } uca_phase_t;

    // Whole register state of the block
    typedef struct packed {
        uca_phase_t phase;
        logic [1:0] settle_cnt;
        logic [8:0] s1;
        logic [8:0] s2;
        logic [8:0] s3;
        logic [8:0] filt;
        logic [15:0] div_cnt;
        logic tick;
        logic [7:0] buf0;
        logic [7:0] buf1;
        logic [1:0] buf_cnt;
        logic tx_busy;
        logic [9:0] tx_shift;
        logic [3:0] tx_bit;
        logic [3:0] tx_os;
        logic tx_line;
        logic ir_line;
        logic rx_busy;
        logic [3:0] rx_bit;
        logic [3:0] rx_os;
        logic [7:0] rx_shift;
        logic [7:0] rx_data;
        logic rx_valid;
        logic rx_frame_err;
        logic cfg_enable;
        logic [7:0] base_hi;
        logic [7:0] base_lo;
        logic [7:0] irq_sel;
        logic clk_sel;
        logic [7:0] cfg_port;
        logic [3:0] modem_status;
        logic [3:0] gpio_in;
        logic rts_n;
        logic dtr_n;
        logic wdt_drive;
    } uca_state_t;

endpackage : uca_pkg

// File: test/uca_chk.sv
// Concurrent checks on the ports of the serial channel A pin and strap block
`timescale 1ns/1ps
`default_nettype none

module uca_chk (
    // Clock, reset, enable
    input wire logic mclk,
    input wire logic rstn,
    input wire logic ce,
    // Stream and phase
    input wire logic straps_done,
    input wire logic tx_ready,
    input wire logic rx_valid,
    // Configuration
    input wire logic cfg_wr,
    input wire logic [7:0] cfg_addr,
    input wire logic [7:0] cfg_wdata,
    input wire logic cfg_enable,
    input wire logic cfg_clk_sel,
    input wire logic [7:0] cfg_index_port,
    input wire logic [7:0] cfg_data_port,
    // Pins
    input wire logic chan_serial_out_o,
    input wire logic chan_serial_out_oe,
    input wire logic infrared_out,
    input wire logic rts_assert,
    input wire logic [1:0] gpo_mode,
    input wire logic [1:0] gpo_level,
    input wire logic chan_request_to_send_n_o,
    input wire logic chan_request_to_send_n_oe,
    input wire logic watchdog_fire,
    input wire logic watchdog_out_n_o,
    input wire logic watchdog_out_n_oe
);
    // ==========================================================
    // Helpers
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    // Level the request pin should take one cycle later
    wire logic rts_want = gpo_mode[0] ? gpo_level[0] : !rts_assert;
    sequence s_wr(a);
        ce && straps_done && cfg_wr && cfg_addr == a;
    endsequence

    // ==========================================================
    // Assertions
    line_idle_a: assert property (!straps_done |-> chan_serial_out_o && !chan_serial_out_oe)
        else $error("serial out not idle high before straps");
    ir_idle_a: assert property (!straps_done |-> !infrared_out)
        else $error("infrared out not low before straps");
    pins_late_a: assert property ((chan_serial_out_oe || chan_request_to_send_n_oe || tx_ready)
        |-> straps_done)
        else $error("pin driven or byte taken before straps latched");
    rts_ctl_a: assert property ($past(ce) && $past(straps_done)
        |-> chan_request_to_send_n_o == $past(rts_want))
        else $error("request pin level wrong");
    wdt_drain_a: assert property ($past(rstn) && $past(ce)
        |-> !watchdog_out_n_o && watchdog_out_n_oe == $past(watchdog_fire))
        else $error("watchdog pin not open drain low");
    en_write_a: assert property (s_wr(8'h30) |=> cfg_enable == $past(cfg_wdata[0]))
        else $error("enable write lost");
    en_keep_a: assert property (straps_done && !(cfg_wr && cfg_addr == 8'h30)
        |=> $stable(cfg_enable))
        else $error("enable changed without write");
    clk_write_a: assert property (s_wr(8'h25) |=> cfg_clk_sel == $past(cfg_wdata[0]))
        else $error("clock select write lost");
    port_pair_a: assert property (cfg_data_port == cfg_index_port + 8'h01
        && (cfg_index_port == 8'h2E || cfg_index_port == 8'h4E))
        else $error("config port pair wrong");
    rx_pulse_a: assert property (rx_valid |=> !rx_valid [*8])
        else $error("receive strobe too long");
endmodule : uca_chk

bind uca_chan uca_chk chk (.mclk, .rstn, .ce, .straps_done, .tx_ready, .rx_valid, .cfg_wr,
    .cfg_addr, .cfg_wdata, .cfg_enable, .cfg_clk_sel, .cfg_index_port, .cfg_data_port,
    .chan_serial_out_o, .chan_serial_out_oe, .infrared_out, .rts_assert, .gpo_mode,
    .gpo_level, .chan_request_to_send_n_o, .chan_request_to_send_n_oe, .watchdog_fire,
    .watchdog_out_n_o, .watchdog_out_n_oe);
`default_nettype wire

// File: test/uca_line_model.sv
// Remote serial device: decodes the wire line and echoes, sends infrared on demand
`timescale 1ns/1ps
`default_nettype none

module uca_line_model #(parameter int BIT = 32) (
    // Clock and decode enable
    input wire logic mclk,
    input wire logic en,
    // Lines
    input wire logic txd,
    output logic rxd,
    output logic irin
);
    logic [8:0] q[$];
    logic [8:0] e;
    logic [7:0] b;
    logic v;
    // Idle levels: wire high, infrared low
    initial begin
        rxd = 1'b1;
        irin = 1'b0;
    end
    // Decode each frame at mid bit, queue the byte for echo
    always begin
        @(negedge txd iff en);
        repeat (BIT / 2) @(posedge mclk);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT) @(posedge mclk);
            b[i] = txd;
        end
        repeat (BIT) @(posedge mclk);
        q.push_back({1'b0, b});
    end
    // Send queued bytes, bit 8 picks the infrared line (level inverted)
    always begin
        while (q.size() == 0) @(posedge mclk);
        e = q.pop_front();
        for (int i = 0; i < 10; i++) begin
            v = (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : e[i - 1];
            @(posedge mclk);
            #1;
            if (e[8]) irin = ~v;
            else rxd = v;
            repeat (BIT - 1) @(posedge mclk);
        end
    end
endmodule : uca_line_model
`default_nettype wire

// File: test/uca_chan_bench.sv
// Self-checking testbench of the serial channel A pin and strap block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin err_count++; \
    $display("[ERR] %s exp %h got %h", n, e, g); end end

module uca_chan_bench;
    import uca_pkg::*;
    // ==========================================================
    // Stimulus and observed signals, named as the ports
    logic mclk = 0, rstn = 0, ce = 1, tx_valid = 0, ir_mode = 0, cfg_wr = 0;
    logic rts_assert = 0, dtr_assert = 0, watchdog_fire = 0, link_on = 0;
    logic [7:0] tx_data = 0, cfg_addr = 0, cfg_wdata = 0, rx_data, exp_v;
    logic [15:0] baud_div = 16'h0001;
    logic [1:0] gpo_mode = 0, gpo_level = 0;
    logic chan_clear_to_send_n = 1, chan_set_ready_n = 1;
    logic chan_carrier_detect_n = 1, chan_ring_indicator_n = 1;
    logic tx_ready, rx_valid, rx_frame_err, cfg_enable, cfg_clk_sel, straps_done;
    logic [7:0] cfg_base_hi, cfg_base_lo, cfg_irq_sel, cfg_index_port, cfg_data_port;
    logic chan_serial_in, chan_serial_out_o, chan_serial_out_oe, infrared_in, infrared_out;
    logic [3:0] modem_status, gpio_in;
    logic chan_request_to_send_n_o, chan_request_to_send_n_oe;
    logic chan_terminal_ready_n_o, chan_terminal_ready_n_oe;
    logic watchdog_out_n_o, watchdog_out_n_oe;
    logic [2:0] strap = 3'h7;
    logic [7:0] e_hi, e_lo, e_irq;
    logic e_en, e_clk;
    logic [31:0] r;
    logic [7:0] exp_q[$];
    logic [15:0] wl[8] = '{16'h3001, 16'h6002, 16'h61E8, 16'h7005,
                           16'h2501, 16'h2500, 16'h31FF, 16'h2501};
    int err_count = 0, checks = 0, seed = 42222;
    int n_ir = 0, n_lo = 0;
    // Pin levels: driver when enabled, else strap pull level
    wire logic chan_serial_out_i = chan_serial_out_oe ? chan_serial_out_o : strap[2];
    wire logic chan_terminal_ready_n_i = chan_terminal_ready_n_oe ? chan_terminal_ready_n_o : strap[1];
    wire logic chan_request_to_send_n_i = chan_request_to_send_n_oe ? chan_request_to_send_n_o : strap[0];

    always #5 mclk = ~mclk;
    uca_chan dut (.mclk, .rstn, .ce, .tx_valid, .tx_ready, .tx_data, .rx_valid, .rx_data,
        .rx_frame_err, .baud_div, .ir_mode, .cfg_wr, .cfg_addr, .cfg_wdata, .cfg_enable,
        .cfg_base_hi, .cfg_base_lo, .cfg_irq_sel, .cfg_clk_sel, .cfg_index_port,
        .cfg_data_port, .straps_done, .chan_serial_in, .chan_serial_out_i, .chan_serial_out_o,
        .chan_serial_out_oe, .infrared_in, .infrared_out, .chan_clear_to_send_n,
        .chan_set_ready_n, .chan_carrier_detect_n, .chan_ring_indicator_n, .modem_status,
        .gpio_in, .rts_assert, .dtr_assert, .gpo_mode, .gpo_level, .chan_request_to_send_n_i,
        .chan_request_to_send_n_o, .chan_request_to_send_n_oe, .chan_terminal_ready_n_i,
        .chan_terminal_ready_n_o, .chan_terminal_ready_n_oe, .watchdog_fire,
        .watchdog_out_n_o, .watchdog_out_n_oe);
    uca_line_model m (.mclk, .en(link_on), .txd(chan_serial_out_i), .rxd(chan_serial_in),
        .irin(infrared_in));

    // ==========================================================
    // Tasks
    task automatic step(int n = 1);
        repeat (n) @(posedge mclk);
        #1;
    endtask : step
    task automatic chk_cfg(logic [7:0] idx);
        `CHK("enable", e_en, cfg_enable)
        `CHK("base_hi", e_hi, cfg_base_hi)
        `CHK("base_lo", e_lo, cfg_base_lo)
        `CHK("irq_sel", e_irq, cfg_irq_sel)
        `CHK("clk_sel", e_clk, cfg_clk_sel)
        `CHK("index", idx, cfg_index_port)
        `CHK("data", idx + 8'h01, cfg_data_port)
    endtask : chk_cfg
    task automatic do_reset(logic [2:0] s);
        rstn = 0;
        strap = s;
        step(3);
        `CHK("tx_rst", 1'b1, chan_serial_out_o)
        `CHK("ir_rst", 1'b0, infrared_out)
        `CHK("oe_rst", 1'b0, chan_request_to_send_n_oe)
        rstn = 1;
        for (int i = 0; i < 12 && straps_done !== 1'b1; i++) step();
        `CHK("done", 1'b1, straps_done)
        e_en = s[2] | s[1];
        e_hi = e_en ? 8'h03 : 8'h00;
        e_lo = s[2] ? 8'hF8 : (s[1] ? 8'hE0 : 8'h00);
        e_irq = e_en ? 8'h03 : 8'h00;
        e_clk = 0;
        chk_cfg(s[0] ? 8'h2E : 8'h4E);
    endtask : do_reset
    task automatic wr(logic [15:0] w);
        cfg_wr = 1;
        {cfg_addr, cfg_wdata} = w;
        step();
        cfg_wr = 0;
        step();
        case (w[15:8])
            8'h30: e_en = w[0];
            8'h60: e_hi = w[7:0];
            8'h61: e_lo = w[7:0];
            8'h70: e_irq = w[7:0];
            8'h25: e_clk = w[0];
            default: ;
        endcase
        chk_cfg(8'h2E);
    endtask : wr
    task automatic put(logic [7:0] d);
        tx_valid = 1;
        tx_data = d;
        for (int i = 0; i < 2000 && tx_ready !== 1'b1; i++) step();
        step();
        exp_q.push_back(d);
    endtask : put
    task automatic drain();
        for (int i = 0; i < 3000 && exp_q.size() != 0; i++) step();
        `CHK("drained", 0, exp_q.size())
    endtask : drain
    task automatic conclude();
        $display("checks %0d errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : conclude

    // Received characters against the oldest expected byte, sampled mid-cycle once settled
    always @(negedge mclk) begin
        if (rx_valid === 1'b1) begin
            exp_v = exp_q.size() ? exp_q.pop_front() : 8'hXX;
            `CHK("rx_data", exp_v, rx_data)
            `CHK("rx_err", 1'b0, rx_frame_err)
        end
    end

    // ==========================================================
    // Main sequence
    initial begin
        do_reset(3'b110);
        do_reset(3'b010);
        do_reset(3'b001);
        foreach (wl[i]) wr(wl[i]);
        // Modem status pins and request pins, random levels and modes
        repeat (6) begin
            r = $random(seed);
            {chan_ring_indicator_n, chan_carrier_detect_n, chan_set_ready_n,
                chan_clear_to_send_n} = r[3:0];
            {rts_assert, dtr_assert, gpo_mode, gpo_level} = r[9:4];
            step(10);
            `CHK("status", ~r[3:0], modem_status)
            `CHK("gpio", r[3:0], gpio_in)
            `CHK("rts", gpo_mode[0] ? gpo_level[0] : ~rts_assert, chan_request_to_send_n_i)
            `CHK("dtr", gpo_mode[1] ? gpo_level[1] : ~dtr_assert, chan_terminal_ready_n_i)
        end
        watchdog_fire = 1;
        step(2);
        `CHK("wdt_on", 2'b10, {watchdog_out_n_oe, watchdog_out_n_o})
        watchdog_fire = 0;
        step(2);
        `CHK("wdt_off", 1'b0, watchdog_out_n_oe)
        // Wire stream, buffer filled until it refuses, echoed back
        link_on = 1;
        for (int i = 0; i < 4; i++) begin
            r = $random(seed);
            put(r[7:0]);
            if (i == 2) `CHK("full", 1'b0, tx_ready)
        end
        tx_valid = 0;
        drain();
        // Infrared receive with quiet low idle
        ir_mode = 1;
        link_on = 0;
        step(40);
        `CHK("ir_idle", 1'b0, infrared_out)
        `CHK("tx_idle", 1'b1, chan_serial_out_o)
        repeat (2) begin
            r = $random(seed);
            exp_q.push_back(r[7:0]);
            m.q.push_back({1'b1, r[7:0]});
        end
        drain();
        // Infrared transmit of an all-zero byte: nine short pulses, wire line stays high
        tx_valid = 1;
        tx_data = 8'h00;
        step();
        tx_valid = 0;
        for (int i = 0; i < 400; i++) begin
            step();
            n_ir += infrared_out;
            n_lo += !chan_serial_out_o;
        end
        `CHK("ir_pulse", 1'b1, n_ir == 53 || n_ir == 54)
        `CHK("ir_wire", 0, n_lo)
        conclude();
    end

    // Hang guard
    initial begin
        #500000;
        err_count++;
        conclude();
    end
endmodule : uca_chan_bench
`default_nettype wire
